/* pllc_top.sv */
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pllc_top import pllc_pkg::*; #(
  parameter int SYNC_LAT = SYNC_CYCLES,
  parameter int STARTUP = STARTUP_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // analogue side
  input wire logic PLL_LOCK_RAW,
  input wire logic [31:0] CAL_FACTORY,
  // pll controls
  output logic PLL_ENABLE,
  output logic [RATIO_INT_W-1:0] LOOP_RATIO_INT,
  output logic [RATIO_FRAC_W-1:0] LOOP_RATIO_FRAC,
  output logic [1:0] FILTER_SEL,
  output logic [1:0] DIVIDE_SEL,
  output logic PLL_LOCKED,
  output logic PLL_CLK_RUN,
  // oscillator trim
  output logic [TEMP_TRIM_W-1:0] TEMP_TRIM,
  output logic [BAND_W-1:0] FREQ_BAND,
  output logic [FREQ_TRIM_W-1:0] FREQ_TRIM,
  // interrupt
  output logic IRQ
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic known(input logic [7:0] addr);
    known = hit(addr, OFF_CTRL_PRIMARY) | hit(addr, OFF_LOOP_RATIO) | hit(addr, OFF_CTRL_B) |
            hit(addr, OFF_OUT_DIV) | hit(addr, OFF_BUSY) | hit(addr, OFF_STATUS) |
            hit(addr, OFF_TRIM) | hit(addr, OFF_IRQ_STATUS) | hit(addr, OFF_IRQ_MASK) |
            hit(addr, OFF_GUARD);
  endfunction : known

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic pready_q;
  logic access_first;
  logic wr_commit;
  logic enable_q;
  logic [RATIO_INT_W+RATIO_FRAC_W-1:0] ratio_q;
  logic [31:0] ctrl_b_q;
  logic [1:0] div_q;
  logic [31:0] trim_q;
  logic trim_loaded_q;
  logic guard_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic lock_prev_q;
  logic run_prev_q;
  logic start_en;
  logic start_ratio;
  logic start_div;
  logic busy_en;
  logic busy_ratio;
  logic busy_div;
  logic en_sync;
  logic [RATIO_INT_W+RATIO_FRAC_W-1:0] ratio_sync;
  logic [RATIO_INT_W+RATIO_FRAC_W-1:0] ratio_wr;
  logic [1:0] div_wr;
  logic [7:0] busy_word;
  logic [7:0] status_word;
  logic [31:0] rd_mux;
  logic wr_ctrl_b;
  logic wr_guard;
  logic wr_trim;
  logic wr_irq_clr;
  logic wr_irq_mask;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // one wait state: data is captured in the first access cycle, write commits on the ready edge
  assign access_first = PSEL && PENABLE && !pready_q;
  assign wr_commit = PSEL && PENABLE && pready_q && PWRITE && known(PADDR);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      PRDATA <= RST_WORD;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      pready_q <= access_first;
      if (access_first) begin
        PRDATA <= PWRITE ? RST_WORD : rd_mux;
        PSLVERR <= !known(PADDR);
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  assign PREADY = pready_q;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign ratio_wr = {PWDATA[RATIO_FRAC_LSB +: RATIO_FRAC_W], PWDATA[RATIO_INT_LSB +: RATIO_INT_W]};
  assign div_wr = PWDATA[DIV_LSB +: 2];

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // guard is applied by the users, since it covers only divider and trim
  assign wr_ctrl_b = wr_commit && hit(PADDR, OFF_CTRL_B);
  assign wr_guard = wr_commit && hit(PADDR, OFF_GUARD);
  assign wr_trim = wr_commit && hit(PADDR, OFF_TRIM);
  assign wr_irq_clr = wr_commit && hit(PADDR, OFF_IRQ_STATUS);
  assign wr_irq_mask = wr_commit && hit(PADDR, OFF_IRQ_MASK);

  assign start_en = wr_commit && hit(PADDR, OFF_CTRL_PRIMARY) && (PWDATA[CTRL_ENABLE_BIT] != enable_q);
  assign start_ratio = wr_commit && hit(PADDR, OFF_LOOP_RATIO) && (ratio_wr != ratio_q);
  // reserved divide code is refused, so it never starts a transfer
  assign start_div = wr_commit && hit(PADDR, OFF_OUT_DIV) && !guard_q && (div_wr != DIVIDE_RESERVED) &&
                     (div_wr != div_q);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      enable_q <= 1'b0;
      ratio_q <= '0;
    end else if (CE) begin
      if (start_en) begin
        enable_q <= PWDATA[CTRL_ENABLE_BIT];
      end
      if (start_ratio) begin
        ratio_q <= ratio_wr;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_b_q <= RST_WORD;
    end else if (CE && wr_ctrl_b) begin
      ctrl_b_q <= RST_WORD;
      ctrl_b_q[FILTER_LSB +: 2] <= PWDATA[FILTER_LSB +: 2];
      ctrl_b_q[FAST_WAKEUP_BIT] <= PWDATA[FAST_WAKEUP_BIT];
      ctrl_b_q[LOCK_OVERRIDE_BIT] <= PWDATA[LOCK_OVERRIDE_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q <= RST_OUT_DIV[1:0];
    end else if (CE && start_div) begin
      div_q <= div_wr;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      guard_q <= 1'b0;
    end else if (CE && wr_guard) begin
      guard_q <= PWDATA[GUARD_BIT];
    end
  end

  // ----------------------------------------
  // oscillator trim
  // ----------------------------------------
  // factory value is taken on the first enabled edge after reset, never inside the reset branch
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trim_q <= RST_WORD;
      trim_loaded_q <= 1'b0;
    end else if (CE) begin
      if (!trim_loaded_q) begin
        trim_q <= CAL_FACTORY & TRIM_MASK;
        trim_loaded_q <= 1'b1;
      end else if (wr_trim && !guard_q) begin
        trim_q <= PWDATA & TRIM_MASK;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TEMP_TRIM <= '0;
      FREQ_BAND <= '0;
      FREQ_TRIM <= '0;
      FILTER_SEL <= FILTER_DEFAULT;
    end else if (CE) begin
      TEMP_TRIM <= trim_q[TEMP_TRIM_LSB +: TEMP_TRIM_W];
      FREQ_BAND <= trim_q[BAND_LSB +: BAND_W];
      FREQ_TRIM <= trim_q[FREQ_TRIM_LSB +: FREQ_TRIM_W];
      FILTER_SEL <= ctrl_b_q[FILTER_LSB +: 2];
    end
  end

  // ----------------------------------------
  // write synchronisation into the pll side
  // ----------------------------------------
  pllc_wsync #(.W(1), .LAT(SYNC_LAT)) u_sync_en (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .start(start_en),
    .din(PWDATA[CTRL_ENABLE_BIT]),
    .busy(busy_en),
    .dout(en_sync)
  );

  pllc_wsync #(.W(RATIO_INT_W + RATIO_FRAC_W), .LAT(SYNC_LAT)) u_sync_ratio (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .start(start_ratio),
    .din(ratio_wr),
    .busy(busy_ratio),
    .dout(ratio_sync)
  );

  pllc_wsync #(.W(2), .LAT(SYNC_LAT)) u_sync_div (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .start(start_div),
    .din(div_wr),
    .busy(busy_div),
    .dout(DIVIDE_SEL)
  );

  assign PLL_ENABLE = en_sync;
  assign LOOP_RATIO_INT = ratio_sync[RATIO_INT_W-1:0];
  assign LOOP_RATIO_FRAC = ratio_sync[RATIO_INT_W +: RATIO_FRAC_W];

  // ----------------------------------------
  // lock and output clock
  // ----------------------------------------
  pllc_lockctl #(.STARTUP(STARTUP)) u_lock (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .enable(en_sync),
    .lock_override(ctrl_b_q[LOCK_OVERRIDE_BIT]),
    .fast_wakeup(ctrl_b_q[FAST_WAKEUP_BIT]),
    .lock_raw(PLL_LOCK_RAW),
    .locked(PLL_LOCKED),
    .running(PLL_CLK_RUN)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    busy_word = RST_BUSY;
    busy_word[BUSY_ENABLE_BIT] = busy_en;
    busy_word[BUSY_RATIO_BIT] = busy_ratio;
    busy_word[BUSY_DIV_BIT] = busy_div;
  end

  always_comb begin
    status_word = RST_STATUS;
    status_word[STAT_LOCK_BIT] = PLL_LOCKED;
    status_word[STAT_RUN_BIT] = PLL_CLK_RUN;
  end

  always_comb begin
    rd_mux = RST_WORD;
    unique case (1'b1)
      hit(PADDR, OFF_CTRL_PRIMARY): rd_mux[CTRL_ENABLE_BIT] = enable_q;
      hit(PADDR, OFF_LOOP_RATIO): begin
        rd_mux[RATIO_INT_LSB +: RATIO_INT_W] = ratio_q[RATIO_INT_W-1:0];
        rd_mux[RATIO_FRAC_LSB +: RATIO_FRAC_W] = ratio_q[RATIO_INT_W +: RATIO_FRAC_W];
      end
      hit(PADDR, OFF_CTRL_B): rd_mux = ctrl_b_q;
      hit(PADDR, OFF_OUT_DIV): rd_mux[DIV_LSB +: 2] = div_q;
      hit(PADDR, OFF_BUSY): rd_mux[7:0] = busy_word;
      hit(PADDR, OFF_STATUS): rd_mux[7:0] = status_word;
      hit(PADDR, OFF_TRIM): rd_mux = trim_q;
      hit(PADDR, OFF_IRQ_STATUS): rd_mux[IRQ_W-1:0] = irq_status_q;
      hit(PADDR, OFF_IRQ_MASK): rd_mux[IRQ_W-1:0] = irq_mask_q;
      hit(PADDR, OFF_GUARD): rd_mux[GUARD_BIT] = guard_q;
      default: rd_mux = RST_WORD;
    endcase
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lock_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else if (CE) begin
      lock_prev_q <= PLL_LOCKED;
      run_prev_q <= PLL_CLK_RUN;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LOCK_RISE_BIT] = PLL_LOCKED && !lock_prev_q;
    irq_event[IRQ_LOCK_LOST_BIT] = !PLL_LOCKED && lock_prev_q;
    irq_event[IRQ_RUN_RISE_BIT] = PLL_CLK_RUN && !run_prev_q;
  end

  assign irq_clear = wr_irq_clr ? PWDATA[IRQ_W-1:0] : '0;

  // a set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_status_q <= '0;
    end else if (CE) begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_mask_q <= '0;
    end else if (CE && wr_irq_mask) begin
      irq_mask_q <= PWDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(irq_status_q & irq_mask_q);
    end
  end
endmodule : pllc_top
`default_nettype wire

/* pllc_pkg.sv */
package pllc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_PRIMARY = 8'h1c;
  localparam logic [7:0] OFF_LOOP_RATIO = 8'h20;
  localparam logic [7:0] OFF_CTRL_B = 8'h24;
  localparam logic [7:0] OFF_OUT_DIV = 8'h28;
  localparam logic [7:0] OFF_BUSY = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_TRIM = 8'h38;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_GUARD = 8'h48;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int FILTER_LSB = 0;
  localparam int FAST_WAKEUP_BIT = 3;
  localparam int LOCK_OVERRIDE_BIT = 12;
  localparam int RATIO_INT_LSB = 0;
  localparam int RATIO_INT_W = 12;
  localparam int RATIO_FRAC_LSB = 16;
  localparam int RATIO_FRAC_W = 4;
  localparam int DIV_LSB = 0;
  localparam int BUSY_ENABLE_BIT = 1;
  localparam int BUSY_RATIO_BIT = 2;
  localparam int BUSY_DIV_BIT = 3;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int TEMP_TRIM_LSB = 16;
  localparam int TEMP_TRIM_W = 6;
  localparam int BAND_LSB = 8;
  localparam int BAND_W = 2;
  localparam int FREQ_TRIM_LSB = 0;
  localparam int FREQ_TRIM_W = 6;
  localparam logic [31:0] TRIM_MASK = 32'h003f033f;
  localparam int GUARD_BIT = 0;
  localparam int IRQ_LOCK_RISE_BIT = 0;
  localparam int IRQ_LOCK_LOST_BIT = 1;
  localparam int IRQ_RUN_RISE_BIT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [1:0] FILTER_DEFAULT = 2'h0;
  localparam logic [1:0] FILTER_LOW_BANDWIDTH_LOOP = 2'h1;
  localparam logic [1:0] FILTER_HIGH_BANDWIDTH_LOOP = 2'h2;
  localparam logic [1:0] FILTER_HIGH_DAMPING_LOOP = 2'h3;
  localparam logic [1:0] DIVIDE_BY_ONE = 2'h0;
  localparam logic [1:0] DIVIDE_BY_TWO = 2'h1;
  localparam logic [1:0] DIVIDE_BY_FOUR = 2'h2;
  localparam logic [1:0] DIVIDE_RESERVED = 2'h3;
  localparam logic [7:0] RST_OUT_DIV = 8'h00;
  localparam logic [7:0] RST_BUSY = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYNC_TIME_NS = 120;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_TIME_NS = 1000;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LK_OFF,
    LK_STARTUP,
    LK_WAIT_LOCK,
    LK_RUN
  } pllc_lock_state_e;
endpackage : pllc_pkg

/* pllc_wsync.sv */
`timescale 1ns/1ps
`default_nettype none
module pllc_wsync import pllc_pkg::*; #(
  parameter int W = 1,
  parameter int LAT = SYNC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // request side
  input wire logic start,
  input wire logic [W-1:0] din,
  output logic busy,
  // pll domain side
  output logic [W-1:0] dout
);
  logic [W-1:0] hold_q;
  logic [7:0] cnt_q;

  // ----------------------------------------
  // transfer
  // ----------------------------------------
  // a new start while busy restarts the count so the last value always lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
      cnt_q <= 8'h00;
      busy <= 1'b0;
      dout <= '0;
    end else if (ce) begin
      if (start) begin
        hold_q <= din;
        cnt_q <= 8'(LAT);
        busy <= 1'b1;
      end else if (busy) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q <= 8'h01) begin
          dout <= hold_q;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule : pllc_wsync
`default_nettype wire

/* pllc_lockctl.sv */
`timescale 1ns/1ps
`default_nettype none
module pllc_lockctl import pllc_pkg::*; #(
  parameter int STARTUP = STARTUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // settings
  input wire logic enable,
  input wire logic lock_override,
  input wire logic fast_wakeup,
  // analogue lock detector
  input wire logic lock_raw,
  // status
  output logic locked,
  output logic running
);
  pllc_lock_state_e state_q;
  logic [15:0] cnt_q;
  logic lock_eff;

  assign lock_eff = lock_override | lock_raw;

  // ----------------------------------------
  // start-up sequencing
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= LK_OFF;
      cnt_q <= 16'h0000;
    end else if (ce) begin
      if (!enable) begin
        state_q <= LK_OFF;
        cnt_q <= 16'h0000;
      end else begin
        unique case (state_q)
          LK_OFF: begin
            state_q <= LK_STARTUP;
            cnt_q <= 16'(STARTUP);
          end
          LK_STARTUP: begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001) begin
              state_q <= LK_WAIT_LOCK;
            end
          end
          LK_WAIT_LOCK: begin
            if (fast_wakeup || lock_eff) begin
              state_q <= LK_RUN;
            end
          end
          LK_RUN: begin
            state_q <= LK_RUN;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked <= 1'b0;
      running <= 1'b0;
    end else if (ce) begin
      // lock only counts once start-up time has passed
      locked <= enable && (state_q == LK_WAIT_LOCK || state_q == LK_RUN) && lock_eff;
      running <= enable && (state_q == LK_RUN);
    end
  end
endmodule : pllc_lockctl
`default_nettype wire

/* pllc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pllc_top_monitor import pllc_pkg::*; #(
  parameter int STARTUP = STARTUP_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pll
  input wire logic PLL_ENABLE,
  input wire logic [1:0] FILTER_SEL,
  input wire logic [1:0] DIVIDE_SEL,
  input wire logic PLL_LOCKED,
  input wire logic PLL_CLK_RUN
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [7:0] en_cnt_q;
  logic wr_b;
  assign wr_b = PSEL && PENABLE && PREADY && PWRITE && (PADDR == OFF_CTRL_B);
  // enabled cycles, saturating: lock and run must never beat start-up
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) en_cnt_q <= 8'h00;
    else if (!PLL_ENABLE) en_cnt_q <= 8'h00;
    else if (en_cnt_q != 8'hff) en_cnt_q <= en_cnt_q + 8'h01;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ready_after_wait_a: assert property (PSEL && PENABLE && !PREADY && CE |=> PREADY)
    else $error("apb answer missing after wait state");
  err_read_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response without ready or with data");
  div_code_legal_a: assert property (DIVIDE_SEL != DIVIDE_RESERVED)
    else $error("reserved divider code reached output");
  filter_by_write_a: assert property ($changed(FILTER_SEL) |-> $past(wr_b) || $past(wr_b, 2))
    else $error("filter select changed without a write");
  lock_off_a: assert property (!PLL_ENABLE && !$past(PLL_ENABLE) |-> !PLL_LOCKED)
    else $error("lock shown while disabled");
  run_off_a: assert property (!PLL_ENABLE && !$past(PLL_ENABLE) |-> !PLL_CLK_RUN)
    else $error("output clock shown while disabled");
  lock_after_start_a: assert property (PLL_LOCKED |-> en_cnt_q >= STARTUP)
    else $error("lock before start-up elapsed");
  run_after_start_a: assert property (PLL_CLK_RUN |-> en_cnt_q >= STARTUP)
    else $error("output clock before start-up elapsed");
  run_holds_a: assert property (PLL_CLK_RUN && PLL_ENABLE |=> PLL_CLK_RUN)
    else $error("output clock dropped while enabled");
endmodule : pllc_top_monitor

bind pllc_top pllc_top_monitor #(.STARTUP(STARTUP)) i_pllc_top_monitor (
  .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PLL_ENABLE(PLL_ENABLE), .FILTER_SEL(FILTER_SEL), .DIVIDE_SEL(DIVIDE_SEL),
  .PLL_LOCKED(PLL_LOCKED), .PLL_CLK_RUN(PLL_CLK_RUN)
);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import pllc_pkg::*;;
  // sync latency long enough that a read right after a write still sees busy
  localparam int SYNC = 6;
  localparam int START = 4;
  logic clk = 1'b0;
  logic rst, ce, psel, penable, pwrite, lock_raw;
  logic [7:0] paddr;
  logic [31:0] pwdata, cal, ratio, prdata;
  logic [1:0] prev, code, filter_sel, divide_sel;
  logic [32:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic pready, pslverr, pll_enable, locked, clk_run, irq;
  logic [RATIO_INT_W-1:0] ratio_int;
  logic [RATIO_FRAC_W-1:0] ratio_frac;
  logic [TEMP_TRIM_W-1:0] temp_trim;
  logic [BAND_W-1:0] freq_band;
  logic [FREQ_TRIM_W-1:0] freq_trim;

  pllc_top #(.SYNC_LAT(SYNC), .STARTUP(START)) i_pllc_top (
    .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PLL_LOCK_RAW(lock_raw), .CAL_FACTORY(cal), .PLL_ENABLE(pll_enable),
    .LOOP_RATIO_INT(ratio_int), .LOOP_RATIO_FRAC(ratio_frac), .FILTER_SEL(filter_sel),
    .DIVIDE_SEL(divide_sel), .PLL_LOCKED(locked), .PLL_CLK_RUN(clk_run),
    .TEMP_TRIM(temp_trim), .FREQ_BAND(freq_band), .FREQ_TRIM(freq_trim), .IRQ(irq)
  );

  always #20 clk = ~clk;

  // ----------------------------------------
  // checking and verdict
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  // read answers are paired with the oldest noted expectation
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(90));
    cal = $urandom;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lock_raw = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_BUSY, 33'h0);
    rd(OFF_STATUS, 33'h0);
    rd(OFF_TRIM, {1'b0, cal & TRIM_MASK});
    check(33'({temp_trim, freq_band, freq_trim}), 33'({cal[21:16], cal[9:8], cal[5:0]}));
    wr(OFF_TRIM, ~cal);
    rd(OFF_TRIM, {1'b0, ~cal & TRIM_MASK});
    check(33'({temp_trim, freq_band, freq_trim}), 33'({~cal[21:16], ~cal[9:8], ~cal[5:0]}));
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL_B, 32'(i));
      repeat (2) @(posedge clk);
      check(33'(filter_sel), 33'(i));
    end
    // codes 1,2,3,0: reserved code must be refused and start no sync
    prev = 2'h0;
    for (int i = 1; i < 5; i++) begin
      code = 2'(i);
      wr(OFF_OUT_DIV, 32'(code));
      rd(OFF_BUSY, (code != DIVIDE_RESERVED && code != prev) ? 33'h8 : 33'h0);
      if (code != DIVIDE_RESERVED) prev = code;
      rd(OFF_BUSY, 33'h0);
      rd(OFF_OUT_DIV, 33'(prev));
      check(33'(divide_sel), 33'(prev));
    end
    ratio = ($urandom & 32'h000f0fff) | 32'h1;
    wr(OFF_LOOP_RATIO, ratio);
    rd(OFF_BUSY, 33'h4);
    rd(OFF_BUSY, 33'h0);
    check(33'({ratio_frac, ratio_int}), 33'({ratio[19:16], ratio[11:0]}));
    wr(OFF_CTRL_PRIMARY, 32'h2);
    rd(OFF_BUSY, 33'h2);
    rd(OFF_BUSY, 33'h0);
    check(33'(pll_enable), 33'h1);
    repeat (20) @(posedge clk);
    rd(OFF_STATUS, 33'h0);
    wr(OFF_IRQ_MASK, 32'h7);
    lock_raw <= 1'b1;
    repeat (5) @(posedge clk);
    rd(OFF_STATUS, 33'h3);
    check(33'({locked, clk_run}), 33'h3);
    check(33'(irq), 33'h1);
    rd(OFF_IRQ_STATUS, 33'h5);
    wr(OFF_IRQ_STATUS, 32'h5);
    repeat (2) @(posedge clk);
    check(33'(irq), 33'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    lock_raw <= 1'b0;
    repeat (5) @(posedge clk);
    rd(OFF_STATUS, 33'h2);
    rd(OFF_IRQ_STATUS, 33'h2);
    check(33'(irq), 33'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check(33'(irq), 33'h1);
    wr(OFF_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    check(33'(irq), 33'h0);
    wr(OFF_CTRL_B, 32'h1000);
    repeat (3) @(posedge clk);
    rd(OFF_STATUS, 33'h3);
    wr(OFF_CTRL_PRIMARY, 32'h0);
    repeat (SYNC + 3) @(posedge clk);
    rd(OFF_STATUS, 33'h0);
    check(33'({locked, clk_run}), 33'h0);
    wr(OFF_CTRL_B, 32'h8);
    wr(OFF_CTRL_PRIMARY, 32'h2);
    repeat (SYNC + START + 8) @(posedge clk);
    rd(OFF_STATUS, 33'h2);
    check(33'({locked, clk_run}), 33'h1);
    wr(OFF_GUARD, 32'h1);
    wr(OFF_OUT_DIV, 32'h1);
    wr(OFF_TRIM, cal);
    rd(OFF_BUSY, 33'h0);
    rd(OFF_OUT_DIV, 33'(prev));
    rd(OFF_TRIM, {1'b0, ~cal & TRIM_MASK});
    wr(OFF_GUARD, 32'h0);
    // clock enable low freezes the sync count mid-flight
    wr(OFF_OUT_DIV, 32'h1);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    check(33'(divide_sel), 33'h0);
    rd(OFF_BUSY, 33'h8);
    rd(OFF_BUSY, 33'h0);
    check(33'(divide_sel), 33'h1);
    wr(OFF_BUSY, 32'hff);
    rd(OFF_BUSY, 33'h0);
    rd(8'hfc, 33'h100000000);
    // let the read checker take the last answer before the verdict
    @(posedge clk);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
